//--- hdl/or_ret_pkg.sv
// Package: operation codes, widths and reset values for the OR/return execution block
package or_ret_pkg;
    localparam int unsigned DATA_W       = 8;
    localparam int unsigned PC_W         = 13;
    localparam int unsigned OP_W         = 3;
    // Operation codes presented by the decoder
    localparam logic [2:0]  OP_NONE      = 3'h0;
    localparam logic [2:0]  OP_OR_MEM    = 3'h1;
    localparam logic [2:0]  OP_OR_IMM    = 3'h2;
    localparam logic [2:0]  OP_OR_TO_MEM = 3'h3;
    localparam logic [2:0]  OP_EXIT      = 3'h4;
    localparam logic [2:0]  OP_EXIT_LIT  = 3'h5;
    localparam logic [2:0]  OP_ISR_EXIT  = 3'h6;
    // Reset values and interrupt vector
    localparam logic [7:0]  WORK_RST     = 8'h00;
    localparam logic [12:0] PC_RST       = 13'h0000;
    localparam logic [12:0] ISR_VECTOR   = 13'h0004;
    localparam logic [1:0]  SYNC_RST     = 2'h0;
endpackage : or_ret_pkg

//--- hdl/or_unit.sv
// Combinational OR with zero detection
`timescale 1ns/1ns
module or_unit
    import or_ret_pkg::*;
(
    // Operands
    input  wire logic [DATA_W-1:0] a_i,
    input  wire logic [DATA_W-1:0] b_i,
    // Result
    output logic      [DATA_W-1:0] y_o,
    output logic                   zero_o
);
    // Bitwise OR and zero test on the full 8-bit result
    always_comb begin
        y_o    = a_i | b_i;
        zero_o = ((a_i | b_i) == '0);
    end
endmodule : or_unit

//--- hdl/or_ret_exec.sv
// Execution stage for OR and return instructions
//
// What this block does
// - OR with memory ORs the work register with the memory byte into the work register and updates zero.
// - OR with immediate ORs the work register with the literal into the work register and updates zero.
// - OR into memory writes the OR of the memory byte and the work register back to that location.
// - A call exit pops the stack into the program counter and leaves every flag unchanged.
// - A call exit with literal pops the program counter and loads the literal into the work register, no flags.
// - An isr exit with no request pending pops the program counter and sets the global interrupt enable.
// - An interrupt already pending at an isr exit is serviced before the main program resumes.
`timescale 1ns/1ns
module or_ret_exec
    import or_ret_pkg::*;
(
    // Clock, enable and reset
    input  wire logic              core_clk_i,
    input  wire logic              clk_en_i,
    input  wire logic              reset_n_i,
    // Decoded instruction
    input  wire logic              op_valid_i,
    input  wire logic [OP_W-1:0]   op_code_i,
    input  wire logic [DATA_W-1:0] literal_i,
    input  wire logic [DATA_W-1:0] mem_rdata_i,
    input  wire logic [PC_W-1:0]   stack_top_i,
    // Interrupt request pin
    input  wire logic              irq_pending_i,
    // Data memory write
    output logic                   mem_we_o,
    output logic      [DATA_W-1:0] mem_wdata_o,
    // Stack pop and program counter
    output logic                   stack_pop_o,
    output logic                   pc_load_o,
    output logic      [PC_W-1:0]   pc_o,
    output logic                   irq_ack_o,
    // Core state
    output logic      [DATA_W-1:0] work_register_o,
    output logic                   zero_flag_o,
    output logic                   global_interrupt_enable_o
);
    // ------------------------------------------------------------
    // Reset and input synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_sync_q;
    logic [1:0] irq_sync_q;
    logic       rst_n;

    // Reset released through two flops
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync_q <= SYNC_RST;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Interrupt pin synchroniser; only bit 1 is read by logic
    // The pin moves through only while the clock enable is high, so a frozen core sees it stand still
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            irq_sync_q <= SYNC_RST;
        end else if (clk_en_i) begin
            irq_sync_q <= {irq_sync_q[0], irq_pending_i};
        end
    end

    // ------------------------------------------------------------
    // Operand selection and OR unit
    // ------------------------------------------------------------
    logic [DATA_W-1:0] or_b;
    logic [DATA_W-1:0] or_y;
    logic              or_zero;
    logic              go;

    // An op counts only on an enabled edge; the literal feeds the OR unit for the immediate op alone
    assign go   = op_valid_i && clk_en_i;
    assign or_b = (op_code_i == OP_OR_IMM) ? literal_i : mem_rdata_i;

    or_unit u_or (
        .a_i    (work_register_o),
        .b_i    (or_b),
        .y_o    (or_y),
        .zero_o (or_zero)
    );

    // ------------------------------------------------------------
    // Work register and zero flag
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            work_register_o <= WORK_RST;
            zero_flag_o     <= 1'b0;
        end else if (go) begin
            // Only the two OR-to-work ops touch zero; returns keep zero, and only an isr exit writes the interrupt enable
            if (op_code_i == OP_OR_MEM || op_code_i == OP_OR_IMM) begin
                work_register_o <= or_y;
                zero_flag_o     <= or_zero;
            end else if (op_code_i == OP_EXIT_LIT) begin
                work_register_o <= literal_i;
            end
        end
    end

    // ------------------------------------------------------------
    // Data memory write-back
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            mem_we_o    <= 1'b0;
            mem_wdata_o <= WORK_RST;
        end else if (clk_en_i) begin
            // Strobe lasts one enabled cycle and holds while the clock enable is low; the data holds until the next OR into memory
            mem_we_o <= op_valid_i && (op_code_i == OP_OR_TO_MEM);
            if (op_valid_i && op_code_i == OP_OR_TO_MEM) begin
                mem_wdata_o <= or_y;
            end
        end
    end

    // ------------------------------------------------------------
    // Stack pop, program counter and interrupt enable
    // ------------------------------------------------------------
    logic is_ret;
    assign is_ret = (op_code_i == OP_EXIT) || (op_code_i == OP_EXIT_LIT) || (op_code_i == OP_ISR_EXIT);

    // Isr exit that finds a request pending chains straight into the interrupt routine
    logic chain_irq;
    assign chain_irq = go && (op_code_i == OP_ISR_EXIT) && irq_sync_q[1];

    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stack_pop_o <= 1'b0;
            pc_load_o   <= 1'b0;
            pc_o        <= PC_RST;
            irq_ack_o   <= 1'b0;
        end else if (clk_en_i) begin
            // Pulses fall again on the next enabled edge
            // A chained isr exit keeps the return address on the stack for the pending routine
            stack_pop_o <= go && is_ret && !chain_irq;
            pc_load_o   <= go && is_ret;
            irq_ack_o   <= 1'b0;
            if (go && is_ret) begin
                if (op_code_i == OP_ISR_EXIT && irq_sync_q[1]) begin
                    pc_o      <= ISR_VECTOR;
                    irq_ack_o <= 1'b1;
                end else begin
                    pc_o <= stack_top_i;
                end
            end
        end
    end

    // Interrupt enable set by isr exit; cleared again when a pending request is taken
    always_ff @(posedge core_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            global_interrupt_enable_o <= 1'b0;
        end else if (go && op_code_i == OP_ISR_EXIT) begin
            global_interrupt_enable_o <= !irq_sync_q[1];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_ret_issue;
        go && is_ret;
    endsequence

    // Isr exit taken while a request is pending
    sequence s_chain_issue;
        go && op_code_i == OP_ISR_EXIT && irq_sync_q[1];
    endsequence

    // Ops outside the OR and return set
    sequence s_quiet_issue;
        go && !is_ret && op_code_i != OP_OR_MEM && op_code_i != OP_OR_IMM && op_code_i != OP_OR_TO_MEM;
    endsequence

    // OR results
    a_or_work_update: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && op_code_i == OP_OR_MEM |=> work_register_o == ($past(work_register_o) | $past(mem_rdata_i)))
        else $error("work register not OR of memory");
    a_or_imm_update: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && op_code_i == OP_OR_IMM |=> work_register_o == ($past(work_register_o) | $past(literal_i)))
        else $error("work register not OR of literal");
    a_mem_write_back: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && op_code_i == OP_OR_TO_MEM |=> mem_we_o && mem_wdata_o == ($past(work_register_o) | $past(mem_rdata_i)))
        else $error("memory write-back wrong");

    // Returns, interrupt chaining and the OR zero flag
    a_exit_pops_pc: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        s_ret_issue ##0 (op_code_i != OP_ISR_EXIT) |=> stack_pop_o && pc_load_o && pc_o == $past(stack_top_i)
            && $stable(zero_flag_o))
        else $error("call exit did not pop pc");
    a_exit_literal_load: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && op_code_i == OP_EXIT_LIT |=> work_register_o == $past(literal_i) && $stable(zero_flag_o))
        else $error("literal not loaded on exit");
    a_isr_exit_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && op_code_i == OP_ISR_EXIT && !irq_sync_q[1] |=> global_interrupt_enable_o && pc_o == $past(stack_top_i))
        else $error("isr exit did not enable interrupts");
    a_pending_serviced: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && op_code_i == OP_ISR_EXIT && irq_sync_q[1] |=> irq_ack_o && pc_o == ISR_VECTOR)
        else $error("pending interrupt not serviced");
    a_zero_flag_value: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && (op_code_i == OP_OR_MEM || op_code_i == OP_OR_IMM) |=> zero_flag_o == (work_register_o == 8'h00))
        else $error("zero flag mismatch");

    // Chaining, flag keeping and quiet ops
    a_chain_keeps_stack: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        s_chain_issue |=> !stack_pop_o && pc_load_o && !global_interrupt_enable_o)
        else $error("chained isr exit popped the stack");
    a_ack_at_vector: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        irq_ack_o |-> pc_load_o && pc_o == ISR_VECTOR)
        else $error("acknowledge without vector");
    a_exit_keeps_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        s_ret_issue ##0 (op_code_i != OP_ISR_EXIT) |=> $stable(global_interrupt_enable_o))
        else $error("call exit changed interrupt enable");
    a_pc_hold_no_ret: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        go && !is_ret |=> !pc_load_o && !stack_pop_o && $stable(pc_o))
        else $error("program counter moved without a return");
    a_quiet_op_idle: assert property (@(posedge core_clk_i) disable iff (!rst_n)
        s_quiet_issue |=> !mem_we_o && $stable(work_register_o) && $stable(zero_flag_o))
        else $error("idle op changed state");
endmodule : or_ret_exec

//--- verif/mem_stack_model.sv
// Data memory and return stack model facing the execution block
`timescale 1ns/1ns
module mem_stack_model
    import or_ret_pkg::*;
(
    // Clock and access
    input  wire logic              core_clk_i,
    input  wire logic              clk_en_i,
    input  wire logic [3:0]        addr_i,
    input  wire logic              mem_we_i,
    input  wire logic [DATA_W-1:0] mem_wdata_i,
    input  wire logic              stack_pop_i,
    // Read side
    output logic      [DATA_W-1:0] mem_rdata_o,
    output logic      [PC_W-1:0]   stack_top_o
);
    logic [DATA_W-1:0] mem_q [16];
    logic [PC_W-1:0]   stk_q [8];
    logic [3:0]        wa_q;
    logic [2:0]        sp_q;
    assign mem_rdata_o = mem_q[addr_i];
    assign stack_top_o = stk_q[sp_q];
    // Write lands on the op's address one edge late; a pop moves down one entry
    // Frozen with the core, so a held strobe writes or pops only once
    always @(posedge core_clk_i) if (clk_en_i) begin
        wa_q <= addr_i;
        if (mem_we_i) mem_q[wa_q] <= mem_wdata_i;
        if (stack_pop_i) sp_q <= sp_q - 3'h1;
    end
    // Fill memory and stack with distinct values
    initial begin
        sp_q = 3'h7;
        for (int i = 0; i < 16; i++) mem_q[i] = 8'(i * 29);
        for (int i = 0; i < 8; i++) stk_q[i] = 13'(i * 397 + 5);
    end
endmodule : mem_stack_model

//--- verif/testbench.sv
// Random op stream with expected-result queue for the execution block
`timescale 1ns/1ns
module testbench
    import or_ret_pkg::*;
;
    typedef struct packed {
        logic [7:0] wk; logic z; logic gie; logic we; logic pop; logic ld; logic ack;
        logic [12:0] pc; logic [7:0] wd;
    } exp_s;
    logic core_clk_i = 1'b0, reset_n_i = 1'b0, clk_en_i = 1'b1, op_valid_i = 1'b0, irq_pending_i = 1'b0;
    logic [2:0] op_code_i = 3'h0;
    logic [7:0] literal_i = 8'h00, mem_rdata_i, mem_wdata_o, work_register_o;
    logic [12:0] stack_top_i, pc_o;
    logic [3:0] addr = 4'h0;
    logic mem_we_o, stack_pop_o, pc_load_o, irq_ack_o, zero_flag_o, global_interrupt_enable_o, v_q = 1'b0;
    int n_fail = 0, n_checks = 0, cyc = 0, seed = 81;
    exp_s q[$], m = '0, e;
    always #4 core_clk_i = ~core_clk_i;
    or_ret_exec dut (.core_clk_i, .clk_en_i, .reset_n_i, .op_valid_i, .op_code_i, .literal_i, .mem_rdata_i,
        .stack_top_i, .irq_pending_i, .mem_we_o, .mem_wdata_o, .stack_pop_o, .pc_load_o, .pc_o, .irq_ack_o,
        .work_register_o, .zero_flag_o, .global_interrupt_enable_o);
    mem_stack_model partner (.core_clk_i, .clk_en_i, .addr_i(addr), .mem_we_i(mem_we_o), .mem_wdata_i(mem_wdata_o),
        .stack_pop_i(stack_pop_o), .mem_rdata_o(mem_rdata_i), .stack_top_o(stack_top_i));
    task print_verdict;
        if (n_fail == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task chk(input logic [31:0] a, input logic [31:0] b);
        n_checks++;
        if (a !== b) begin
            n_fail++;
            $display("Error t=%0t got %h exp %h", $time, a, b);
        end
    endtask : chk
    // Drive one op and note what it should leave behind
    task automatic issue(input logic [2:0] op, input logic en);
        logic [7:0] lit;
        exp_s       keep;
        keep = m;
        lit = ($random(seed) & 1) ? 8'h00 : 8'($random(seed));
        @(posedge core_clk_i);
        op_valid_i <= 1'b1;
        op_code_i <= op;
        literal_i <= lit;
        clk_en_i <= en;
        addr <= 4'($random(seed));
        #1;
        {m.we, m.pop, m.ld, m.ack} = 4'h0;
        case (op)
            OP_OR_MEM, OP_OR_IMM: begin
                m.wk = m.wk | (op == OP_OR_MEM ? mem_rdata_i : lit);
                m.z = (m.wk == 8'h00);
            end
            OP_OR_TO_MEM: {m.we, m.wd} = {1'b1, mem_rdata_i | m.wk};
            OP_EXIT, OP_EXIT_LIT, OP_ISR_EXIT: {m.pop, m.ld, m.pc} = {2'h3, stack_top_i};
            default: ;
        endcase
        if (op == OP_EXIT_LIT) m.wk = lit;
        if (op == OP_ISR_EXIT) {m.ack, m.gie} = {irq_pending_i, !irq_pending_i};
        if (op == OP_ISR_EXIT && irq_pending_i) {m.pc, m.pop} = {ISR_VECTOR, 1'b0};
        // A refused op leaves the model as it was
        if (en) q.push_back(m);
        else m = keep;
    endtask : issue
    // Taken ops and the cycle limit
    always @(posedge core_clk_i) begin
        v_q <= op_valid_i & clk_en_i;
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    // Compare outputs with the oldest note one cycle after each taken op
    always @(negedge core_clk_i) if (v_q && q.size() > 0) begin
        e = q.pop_front();
        chk(work_register_o, e.wk);
        chk({zero_flag_o, global_interrupt_enable_o}, {e.z, e.gie});
        chk({mem_we_o, stack_pop_o, pc_load_o, irq_ack_o}, {e.we, e.pop, e.ld, e.ack});
        if (e.ld) chk(pc_o, e.pc);
        if (e.we) chk(mem_wdata_o, e.wd);
    end
    // Reset, then pairs of back-to-back ops with the interrupt pin settled first
    initial begin
        repeat (10) @(posedge core_clk_i);
        chk({work_register_o, zero_flag_o, global_interrupt_enable_o}, 32'h0);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        for (int i = 0; i < 80; i++) begin
            @(posedge core_clk_i);
            irq_pending_i <= 1'($random(seed));
            op_valid_i <= 1'b0;
            clk_en_i <= 1'b1;
            repeat (3) @(posedge core_clk_i);
            issue(3'($random(seed)), ($random(seed) % 8) != 0);
            issue(3'($random(seed)), ($random(seed) % 8) != 0);
        end
        @(posedge core_clk_i);
        op_valid_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
        print_verdict();
    end
endmodule : testbench
